// ===== common/rcvd_map.vh
// Register map and field positions of the regulator control block
`ifndef RCVD_MAP_VH
`define RCVD_MAP_VH
`define RCVD_REG_CTRL_IDX 8'hC9
`define RCVD_REG_CTRL_ADDR 12'h324
`define RCVD_REG_CFG_ADDR 12'h000
`define RCVD_BIT_REG_OFF 7
`define RCVD_BIT_PRESENCE 6
`define RCVD_BIT_POLARITY 5
`define RCVD_BIT_LOW_POWER 4
`define RCVD_CTRL_RESET 8'h00
`define RCVD_CTRL_WMASK 8'hB0
`define RCVD_CFG_RESET 8'h00
`define RCVD_BIT_IRQ_EN 0
`define RCVD_BIT_RST_EN 1
`define RCVD_CFG_WMASK 8'h03
`endif

// ===== hw/rcvd_sync2.v
// Two-stage synchroniser for one level from outside the clock domain
`timescale 1ns/1ns
module rcvd_sync2 (
  input wire clk,
  input wire rst,
  input wire din,
  output wire dout
);
  reg meta_q;
  reg sync_q;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end
  assign dout = sync_q;
endmodule // rcvd_sync2

// ===== hw/rcvd_match.v
// Polarity match of the supply level against the selected event level
`timescale 1ns/1ns
module rcvd_match (
  input wire level,
  input wire polarity,
  output wire match
);
  // Polarity 1 matches high, 0 matches low
  assign match = ~(level ^ polarity);
endmodule // rcvd_match

// ===== hw/rcvd_top.v
// Regulator control and supply presence register block on APB
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ns
`include "rcvd_map.vh"
module rcvd_top (
  input wire clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire supply_present,
  output reg regulator_off,
  output reg low_power_select,
  output reg supply_irq,
  output reg supply_reset_req
);
  ////////////////////////////////////////////////////////////////////////
  // Reset words split into fields below
  localparam [7:0] CTRL_RST = `RCVD_CTRL_RESET;
  localparam [7:0] CFG_RST = `RCVD_CFG_RESET;

  // Bus phase decode
  wire setup;
  wire access;
  wire hit_ctrl;
  wire hit_cfg;
  wire hit_any;
  wire wr_ok;
  wire wr_ctrl;
  wire wr_cfg;
  wire rd_setup;

  // Supply level path
  wire level_s;
  wire match;

  // Read views of the two words
  wire [7:0] ctrl_view;
  wire [7:0] cfg_view;

  // Control word fields
  reg reg_off_q;
  reg reg_off_d;
  reg polarity_q;
  reg polarity_d;
  reg low_power_q;
  reg low_power_d;

  // Configuration word fields
  reg irq_en_q;
  reg irq_en_d;
  reg rst_en_q;
  reg rst_en_d;

  // Next values of the bus response flops
  reg [31:0] prdata_d;
  reg pready_d;
  reg pslverr_d;

  // Next values of the output flops
  reg regulator_off_d;
  reg low_power_select_d;
  reg supply_irq_d;
  reg supply_reset_req_d;

  assign setup = psel & ~penable;
  // Commit only where the master samples pready high
  assign access = psel & penable & pready;
  assign hit_ctrl = (paddr == `RCVD_REG_CTRL_ADDR);
  assign hit_cfg = (paddr == `RCVD_REG_CFG_ADDR);
  assign hit_any = hit_ctrl | hit_cfg;
  // Lane 0 holds the whole byte; upper lanes alone write nothing
  assign wr_ok = access & pwrite & pstrb[0];
  assign wr_ctrl = wr_ok & hit_ctrl;
  assign wr_cfg = wr_ok & hit_cfg;
  assign rd_setup = setup & ~pwrite;

  rcvd_sync2 u_sync (
    .clk(clk),
    .rst(rst),
    .din(supply_present),
    .dout(level_s)
  );

  rcvd_match u_match (
    .level(level_s),
    .polarity(polarity_q),
    .match(match)
  );

  ////////////////////////////////////////////////////////////////////////
  // Read views: status bit is live, reserved bits read as zero
  assign ctrl_view = {reg_off_q, level_s,
    polarity_q, low_power_q, 4'h0};
  assign cfg_view = {6'h00, rst_en_q, irq_en_q};

  ////////////////////////////////////////////////////////////////////////
  // Regulator off field
  always @* begin
    if (wr_ctrl) begin
      reg_off_d = pwdata[`RCVD_BIT_REG_OFF];
    end else begin
      reg_off_d = reg_off_q;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_off_q <= CTRL_RST[`RCVD_BIT_REG_OFF];
    end else begin
      reg_off_q <= reg_off_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Event polarity field, high or low supply level
  always @* begin
    if (wr_ctrl) begin
      polarity_d = pwdata[`RCVD_BIT_POLARITY];
    end else begin
      polarity_d = polarity_q;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      polarity_q <= CTRL_RST[`RCVD_BIT_POLARITY];
    end else begin
      polarity_q <= polarity_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Low-power suspend field
  always @* begin
    if (wr_ctrl) begin
      low_power_d = pwdata[`RCVD_BIT_LOW_POWER];
    end else begin
      low_power_d = low_power_q;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      low_power_q <= CTRL_RST[`RCVD_BIT_LOW_POWER];
    end else begin
      low_power_q <= low_power_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt enable in the separate configuration word
  // Kept out of the control word, whose free bits are reserved
  always @* begin
    if (wr_cfg) begin
      irq_en_d = pwdata[`RCVD_BIT_IRQ_EN];
    end else begin
      irq_en_d = irq_en_q;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_en_q <= CFG_RST[`RCVD_BIT_IRQ_EN];
    end else begin
      irq_en_q <= irq_en_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Reset-source enable
  always @* begin
    if (wr_cfg) begin
      rst_en_d = pwdata[`RCVD_BIT_RST_EN];
    end else begin
      rst_en_d = rst_en_q;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rst_en_q <= CFG_RST[`RCVD_BIT_RST_EN];
    end else begin
      rst_en_q <= rst_en_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Zero-wait slave: pready follows every setup by one cycle
  always @* begin
    pready_d = setup;
  end

  // Unmapped addresses answer with an error, writes there are dropped
  always @* begin
    pslverr_d = setup & ~hit_any;
  end

  // Read data captured at setup, held until the next read
  always @* begin
    prdata_d = prdata;
    if (rd_setup) begin
      if (hit_ctrl) begin
        prdata_d = {24'h000000, ctrl_view};
      end else if (hit_cfg) begin
        prdata_d = {24'h000000, cfg_view};
      end else begin
        prdata_d = 32'h0000_0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Response flops, cleared by reset
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pready <= 1'h0;
    end else begin
      pready <= pready_d;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pslverr <= 1'h0;
    end else begin
      pslverr <= pslverr_d;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= prdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // No pending flag: requests follow the match every cycle
  always @* begin
    regulator_off_d = reg_off_q;
  end

  always @* begin
    low_power_select_d = low_power_q;
  end

  always @* begin
    supply_irq_d = irq_en_q & match;
  end

  always @* begin
    supply_reset_req_d = rst_en_q & match;
  end

  ////////////////////////////////////////////////////////////////////////
  // Every output leaves straight from a flop
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      regulator_off <= 1'h0;
    end else begin
      regulator_off <= regulator_off_d;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      low_power_select <= 1'h0;
    end else begin
      low_power_select <= low_power_select_d;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      supply_irq <= 1'h0;
    end else begin
      supply_irq <= supply_irq_d;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      supply_reset_req <= 1'h0;
    end else begin
      supply_reset_req <= supply_reset_req_d;
    end
  end
endmodule // rcvd_top

// ===== tb/rcvd_vbus.sv
// Supply line model for the presence pin
`timescale 1ns/1ns
module rcvd_vbus (
  input wire clk,
  input wire want,
  output logic supply_present = 1'h0
);
  always @(posedge clk) supply_present <= want;
endmodule // rcvd_vbus

// ===== tb/rcvd_chk.sv
// Port checks of the regulator register block
`timescale 1ns/1ns
module rcvd_chk (
  input wire clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire [3:0] pstrb,
  input wire pready,
  input wire pslverr,
  input wire supply_present,
  input wire regulator_off,
  input wire low_power_select,
  input wire supply_irq,
  input wire supply_reset_req
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire wr = psel && !penable && pwrite && paddr == 12'h324 && pstrb[0];
  wire rd = pready && !pwrite && paddr == 12'h324;
  a_ready_next: assert property (psel && !penable |=> pready)
    else $error("no ready");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("long ready");
  a_err_map: assert property (pready |->
    pslverr == (paddr != 12'h324 && paddr != 12'h0)) else $error("err");
  a_rsvd_zero: assert property (rd |-> prdata[3:0] == 4'h0)
    else $error("rsvd");
  a_off_write: assert property (wr |-> ##3
    regulator_off == $past(pwdata[7], 3)) else $error("off");
  a_mode_write: assert property (wr |-> ##3
    low_power_select == $past(pwdata[4], 3)) else $error("mode");
  a_ctl_hold: assert property (!psel && !$past(psel) |=>
    $stable({regulator_off, low_power_select})) else $error("hold");
  a_live_bit: assert property (rd |-> prdata[6] ==
    $past(supply_present, 3) || prdata[6] == $past(supply_present, 4))
    else $error("bit6");
  a_supply_level: assert property (!psel && !$past(psel) &&
    !$past(psel, 2) && $past(supply_present, 3) == $past(supply_present, 4)
    |-> $stable(supply_irq) && $stable(supply_reset_req))
    else $error("supply request changed without cause");
endmodule // rcvd_chk

// ===== tb/regulator_control_vbus_detect_bench.sv
// Bench for the regulator control register block
`timescale 1ns/1ns
module regulator_control_vbus_detect_bench;
  logic clk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0;
  logic pwrite = 1'h0, want = 1'h0, pready, pslverr, supply_present;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [3:0] pstrb = 4'hF;
  logic regulator_off, low_power_select, supply_irq, supply_reset_req;
  int mismatches = 0, n_tests = 0, cyc = 0;
  always #5 clk = ~clk;
  rcvd_vbus vb (
    .clk(clk),
    .want(want),
    .supply_present(supply_present)
  );
  rcvd_top uut (
    .clk(clk),
    .rst(rst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .supply_present(supply_present),
    .regulator_off(regulator_off),
    .low_power_select(low_power_select),
    .supply_irq(supply_irq),
    .supply_reset_req(supply_reset_req)
  );
  task chk(input [31:0] g, e);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("Error %0t: %h vs %h", $time, g, e);
    end
  endtask
  task acc(input w, input [11:0] a, input [31:0] d);
    @(posedge clk);
    psel <= 1'h1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk) penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    // Error flag folded into bit 31, which reads zero
    r = prdata | {pslverr, 31'h0};
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task rd(input [11:0] a, input [31:0] e);
    acc(1'h0, a, 32'h0);
    chk(r, e);
  endtask
  task report_and_stop;
    $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge clk) if (++cyc == 2000) begin
    mismatches++;
    report_and_stop;
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'h0;
    rd(12'h324, 32'h0);
    acc(1'h1, 12'h324, 32'hF0);
    rd(12'h324, 32'hB0);
    chk({regulator_off, low_power_select}, 32'h3);
    acc(1'h1, 12'h0, 32'h3);
    want <= 1'h1;
    repeat (6) @(posedge clk);
    chk({supply_irq, supply_reset_req}, 32'h3);
    rd(12'h324, 32'hF0);
    acc(1'h1, 12'h324, 32'h0);
    rd(12'h324, 32'h40);
    chk({regulator_off, supply_irq, supply_reset_req}, 32'h0);
    want <= 1'h0;
    repeat (6) @(posedge clk);
    chk({supply_irq, supply_reset_req}, 32'h3);
    rd(12'h8, 32'h80000000);
    report_and_stop;
  end
endmodule // regulator_control_vbus_detect_bench
bind rcvd_top rcvd_chk u_chk (
  .clk(clk),
  .rst(rst),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .prdata(prdata),
  .pstrb(pstrb),
  .pready(pready),
  .pslverr(pslverr),
  .supply_present(supply_present),
  .regulator_off(regulator_off),
  .low_power_select(low_power_select),
  .supply_irq(supply_irq),
  .supply_reset_req(supply_reset_req)
);
